/* logic/ssb_params.svh */
// constants shared by the controller and the bench of the double-data-rate burst memory link
`ifndef SSB_PARAMS_SVH
`define SSB_PARAMS_SVH

// ----------------------------------------
// controller register offsets (byte addresses)
// ----------------------------------------
`define SSB_OFF_CMD    12'h000
`define SSB_OFF_ADDR   12'h004
`define SSB_OFF_STATUS 12'h008
`define SSB_OFF_WDATA0 12'h010
`define SSB_OFF_RDATA0 12'h020

// ----------------------------------------
// field positions
// ----------------------------------------
`define SSB_CMD_GO     0
`define SSB_CMD_WRITE  1
`define SSB_CMD_BANK_A 2
`define SSB_CMD_BANK_B 3
`define SSB_STAT_BUSY  0
`define SSB_STAT_DONE  1

// ----------------------------------------
// reset values and burst shape
// ----------------------------------------
`define SSB_RST_ADDR   32'h0000_0000
`define SSB_RST_BANK   2'h0
`define SSB_BURST_LEN  4

`endif

/* logic/ssb_pkg.sv */
// types shared by both ends of the burst memory link
package ssb_pkg;

  // device operation register: gray order along deselect, read, write
  typedef enum logic [1:0] {
    SSB_OP_BANK_OFF = 2'h0,
    SSB_OP_DESEL    = 2'h1,
    SSB_OP_READ     = 2'h3,
    SSB_OP_WRITE    = 2'h2
  } ssb_op_e;

  // controller sequencer
  typedef enum logic [2:0] {
    SSB_ST_IDLE  = 3'h0,
    SSB_ST_CMD   = 3'h1,
    SSB_ST_CONT  = 3'h3,
    SSB_ST_TAIL  = 3'h2,
    SSB_ST_DRAIN = 3'h6
  } ssb_state_e;

endpackage

/* logic/ssb_if.sv */
// pin bundle between the memory controller and the burst memory device
`timescale 1ns/10ps

interface ssb_if #(
  parameter int ADDR_W = 18,
  parameter int DATA_W = 36
);
  logic [ADDR_W-1:0] addr;
  logic              advance_load;
  logic              write_n;
  logic              primary_select_n;
  logic              prog_select_a;
  logic              prog_select_b;
  logic [DATA_W-1:0] dq_ctl_out;
  logic              dq_ctl_oe_n;
  logic [DATA_W-1:0] dq_dev_out;
  logic              dq_dev_oe_n;
  logic [DATA_W-1:0] dq;
  logic              echo_clock_one;
  logic              echo_clock_one_n;
  logic              echo_clock_two;
  logic              echo_clock_two_n;
  logic              echo_oe_n;

  // resolved shared data wire; an undriven bus reads as zero
  assign dq = !dq_dev_oe_n ? dq_dev_out : (!dq_ctl_oe_n ? dq_ctl_out : '0);

  modport device (
    input  addr, advance_load, write_n, primary_select_n, prog_select_a, prog_select_b, dq,
    output dq_dev_out, dq_dev_oe_n, echo_clock_one, echo_clock_one_n,
           echo_clock_two, echo_clock_two_n, echo_oe_n
  );

  modport ctrl (
    output addr, advance_load, write_n, primary_select_n, prog_select_a, prog_select_b,
           dq_ctl_out, dq_ctl_oe_n,
    input  dq, echo_clock_one, echo_clock_one_n, echo_clock_two, echo_clock_two_n, echo_oe_n
  );
endinterface

/* logic/ssb_device.sv */
// burst memory device end: command decode, burst counter, ddr data and echo clocks
//
// Summary of operation
// - inputs sampled at rising edge, straps static
// - write data captured on both clock edges
// - controller starts each access with load low
// - all three selects needed to activate
// - only programmable deselect stops echo clocks
// - read word at rise, second at fall
// - linear burst order only
// - write needs selects, write low, load low
// - write data starts at following rising edge
// - load high advances internal burst counter
// - counter returns to base after four
// - lowest address bit counts linearly wrapping
// - counter wraps on third rising edge
// - lowest address bit sets the burst start
// - true and inverted echo clocks track data
// - echo shutdown pipelined like data drivers
// - strap sets programmable select polarity
// - four banks strapped in binary sequence
// - deselect before reading a new bank (ssb_ctrl issues the read to a new bank directly)
// - drive strap low means strong drive
// - data released one cycle after deselect/write
// - echo released one cycle after bank deselect
// - second continue wraps to base address
`timescale 1ns/10ps

module ssb_device
  import ssb_pkg::*;
#(
  parameter int ADDR_W = 18,
  parameter int DATA_W = 36
) (
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic polarity_strap_a,
  input  wire logic polarity_strap_b,
  input  wire logic drive_strength_strap,
  output logic      strong_drive,
  ssb_if.device     pins
);

  localparam int IDX_W = ADDR_W + 1;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // array index: upper pins, burst bit in place of the lowest pin, word half
  function automatic logic [IDX_W-1:0] word_index(input logic [ADDR_W-1:0] base,
                                                  input logic              burst_bit,
                                                  input logic              half);
    word_index = {base[ADDR_W-1:1], burst_bit, half};
  endfunction

  // ----------------------------------------
  // strap synchronisers
  // ----------------------------------------
  logic [2:0] strap_a_reg;
  logic [2:0] strap_b_reg;
  logic [2:0] strap_z_reg;
  logic       pol_a_reg;
  logic       pol_b_reg;
  logic       drive_weak_reg;

  always_ff @(posedge clock) begin
    strap_a_reg <= {strap_a_reg[1:0], polarity_strap_a};
    strap_b_reg <= {strap_b_reg[1:0], polarity_strap_b};
    strap_z_reg <= {strap_z_reg[1:0], drive_strength_strap};
  end

  // a strap value counts once stages two and three agree
  always_ff @(posedge clock) begin
    if (srst) begin
      pol_a_reg      <= 1'b1;
      pol_b_reg      <= 1'b1;
      drive_weak_reg <= 1'b0;
    end else begin
      if (strap_a_reg[2] == strap_a_reg[1]) pol_a_reg <= strap_a_reg[2];
      if (strap_b_reg[2] == strap_b_reg[1]) pol_b_reg <= strap_b_reg[2];
      if (strap_z_reg[2] == strap_z_reg[1]) drive_weak_reg <= strap_z_reg[2];
    end
  end

  assign strong_drive = ~drive_weak_reg;

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  logic    bank_true;
  logic    is_load;
  ssb_op_e load_op;
  ssb_op_e op_reg;
  ssb_op_e op_next;
  logic [ADDR_W-1:0] base_reg;
  logic              burst_reg;
  logic              burst_next;

  assign bank_true = (pins.prog_select_a == pol_a_reg) &&
                     (pins.prog_select_b == pol_b_reg);
  assign is_load   = ~pins.advance_load;
  assign load_op   = !bank_true             ? SSB_OP_BANK_OFF :
                     pins.primary_select_n  ? SSB_OP_DESEL :
                     !pins.write_n          ? SSB_OP_WRITE : SSB_OP_READ;
  // a continue keeps the op; deselected states simply hold
  assign op_next    = is_load ? load_op : op_reg;
  // linear count on the burst bit: base, base+1, base (wrap on third edge)
  assign burst_next = is_load ? pins.addr[0] :
                      ((op_reg == SSB_OP_READ || op_reg == SSB_OP_WRITE) ?
                       ~burst_reg : burst_reg);

  always_ff @(posedge clock) begin
    if (srst) begin
      op_reg    <= SSB_OP_BANK_OFF;
      burst_reg <= 1'b0;
      base_reg  <= '0;
    end else begin
      op_reg    <= op_next;
      burst_reg <= burst_next;
      if (is_load) base_reg <= pins.addr;
    end
  end

  // ----------------------------------------
  // storage and late write
  // ----------------------------------------
  logic [DATA_W-1:0] mem [0:(2**IDX_W)-1];
  logic              wr_pend_reg;
  logic [IDX_W-1:0]  wr_idx_reg;
  logic [DATA_W-1:0] wr_rise_reg;
  logic [DATA_W-1:0] wr_fall_reg;
  logic [IDX_W-1:0]  cur_even;
  logic              fwd_hit;
  logic [DATA_W-1:0] rd_rise;
  logic [DATA_W-1:0] rd_fall;

  assign cur_even = word_index(base_reg, burst_reg, 1'b0);
  // a write still waiting for commit is forwarded so reads stay coherent
  assign fwd_hit  = wr_pend_reg && (wr_idx_reg == cur_even);
  assign rd_rise  = fwd_hit ? wr_rise_reg : mem[cur_even];
  assign rd_fall  = fwd_hit ? wr_fall_reg : mem[word_index(base_reg, burst_reg, 1'b1)];

  always_ff @(posedge clock) begin
    if (wr_pend_reg) begin
      mem[wr_idx_reg]        <= wr_rise_reg;
      mem[{wr_idx_reg[IDX_W-1:1], 1'b1}] <= wr_fall_reg;
    end
  end

  // rising half of a write beat: taken the edge after the command
  always_ff @(posedge clock) begin
    if (srst) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= '0;
      wr_rise_reg <= '0;
    end else begin
      wr_pend_reg <= (op_reg == SSB_OP_WRITE);
      wr_idx_reg  <= cur_even;
      wr_rise_reg <= pins.dq;
    end
  end

  // falling half of the same beat
  always_ff @(negedge clock) begin
    wr_fall_reg <= pins.dq;
  end

  // ----------------------------------------
  // double-edge output registers
  // ----------------------------------------
  // pin value is pos_reg ^ neg_reg, so each edge owns one register and
  // the pin changes on both edges without a clock-driven mux
  logic [DATA_W-1:0] dq_pos_reg;
  logic [DATA_W-1:0] dq_neg_reg;
  logic [DATA_W-1:0] fall_hold_reg;
  logic              dq_on_reg;
  logic              cq_on_reg;
  logic              cq_pos_reg;
  logic              cq_neg_reg;
  logic              echo;

  always_ff @(posedge clock) begin
    if (srst) begin
      dq_pos_reg    <= '0;
      fall_hold_reg <= '0;
      dq_on_reg     <= 1'b0;
      cq_on_reg     <= 1'b0;
      cq_pos_reg    <= 1'b0;
    end else begin
      // only a live read loads the pair: an unwritten word in the xor
      // loop would otherwise stay unknown for good
      if (op_reg == SSB_OP_READ) begin
        dq_pos_reg    <= rd_rise ^ dq_neg_reg;
        fall_hold_reg <= rd_fall;
      end
      dq_on_reg     <= (op_reg == SSB_OP_READ);
      cq_on_reg     <= (op_reg != SSB_OP_BANK_OFF);
      cq_pos_reg    <= ~cq_neg_reg;
    end
  end

  always_ff @(negedge clock) begin
    if (srst) begin
      dq_neg_reg <= '0;
      cq_neg_reg <= 1'b0;
    end else begin
      dq_neg_reg <= fall_hold_reg ^ dq_pos_reg;
      cq_neg_reg <= cq_pos_reg;
    end
  end

  assign echo                  = cq_pos_reg ^ cq_neg_reg;
  assign pins.dq_dev_out       = dq_pos_reg ^ dq_neg_reg;
  assign pins.dq_dev_oe_n      = ~dq_on_reg;
  assign pins.echo_clock_one   = echo;
  assign pins.echo_clock_one_n = ~echo;
  assign pins.echo_clock_two   = echo;
  assign pins.echo_clock_two_n = ~echo;
  assign pins.echo_oe_n        = ~cq_on_reg;

endmodule

/* logic/ssb_ctrl.sv */
// memory controller end: apb register block driving four-word bursts
`timescale 1ns/10ps
`include "ssb_params.svh"

module ssb_ctrl
  import ssb_pkg::*;
#(
  parameter int ADDR_W = 18,
  parameter int DATA_W = 36
) (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  ssb_if.ctrl              pins
);

  // ----------------------------------------
  // register block
  // ----------------------------------------
  ssb_state_e        st_reg;
  logic              wr_op_reg;
  logic [1:0]        bank_reg;
  logic              done_reg;
  logic [31:0]       addr_reg;
  logic [31:0]       wdata_reg [0:3];
  logic [31:0]       rdata_reg [0:3];
  logic              acc;
  logic              wr_acc;
  logic              sel_cmd;
  logic              sel_addr;
  logic              sel_stat;
  logic              sel_wd;
  logic              sel_rd;
  logic              go;
  logic [1:0]        widx;

  assign acc      = psel && penable;
  assign wr_acc   = acc && pwrite;
  assign sel_cmd  = (paddr == `SSB_OFF_CMD);
  assign sel_addr = (paddr == `SSB_OFF_ADDR);
  assign sel_stat = (paddr == `SSB_OFF_STATUS);
  assign sel_wd   = (paddr[11:4] == `SSB_OFF_WDATA0 >> 4) && (paddr[1:0] == 2'h0);
  assign sel_rd   = (paddr[11:4] == `SSB_OFF_RDATA0 >> 4) && (paddr[1:0] == 2'h0);
  assign widx     = paddr[3:2];
  // a start while busy is ignored
  assign go       = wr_acc && sel_cmd && pwdata[`SSB_CMD_GO] && (st_reg == SSB_ST_IDLE);
  assign pready   = 1'b1;
  assign pslverr  = acc && !(sel_cmd || sel_addr || sel_stat || sel_wd || sel_rd);
  assign prdata   = !acc     ? 32'h0000_0000 :
                    sel_cmd  ? {28'h000_0000, bank_reg[1], bank_reg[0], wr_op_reg, 1'b0} :
                    sel_addr ? addr_reg :
                    sel_stat ? {30'h0000_0000, done_reg, st_reg != SSB_ST_IDLE} :
                    sel_wd   ? wdata_reg[widx] :
                    sel_rd   ? rdata_reg[widx] : 32'h0000_0000;

  always_ff @(posedge clock) begin
    if (srst) begin
      addr_reg  <= `SSB_RST_ADDR;
      bank_reg  <= `SSB_RST_BANK;
      wr_op_reg <= 1'b0;
    end else if (wr_acc) begin
      if (sel_addr) addr_reg <= pwdata;
      if (sel_wd) wdata_reg[widx] <= pwdata;
      if (go) begin
        wr_op_reg <= pwdata[`SSB_CMD_WRITE];
        bank_reg  <= {pwdata[`SSB_CMD_BANK_B], pwdata[`SSB_CMD_BANK_A]};
      end
    end
  end

  // ----------------------------------------
  // burst sequencer
  // ----------------------------------------
  // every burst ends with a primary deselect, but bank_reg changes on the start, so a
  // new bank gets the read with no deselect of its own and starts echo and data together
  ssb_state_e st_next;
  logic [DATA_W-1:0] cap_neg_reg;
  logic [DATA_W-1:0] dq_pos_reg;
  logic [DATA_W-1:0] dq_neg_reg;
  logic              dq_on_reg;

  always_comb begin
    case (st_reg)
      SSB_ST_IDLE:  st_next = go ? SSB_ST_CMD : SSB_ST_IDLE;
      SSB_ST_CMD:   st_next = SSB_ST_CONT;
      SSB_ST_CONT:  st_next = SSB_ST_TAIL;
      SSB_ST_TAIL:  st_next = SSB_ST_DRAIN;
      SSB_ST_DRAIN: st_next = SSB_ST_IDLE;
      default:      st_next = SSB_ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st_reg   <= SSB_ST_IDLE;
      done_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      // a new start clears done; completion sets it
      if (go) done_reg <= 1'b0;
      else if (st_reg == SSB_ST_DRAIN) done_reg <= 1'b1;
    end
  end

  // read words: rise word taken at the falling edge, fall word at next rise
  always_ff @(negedge clock) begin
    cap_neg_reg <= pins.dq;
  end

  always_ff @(posedge clock) begin
    if (!wr_op_reg && st_reg == SSB_ST_TAIL) begin
      rdata_reg[0] <= cap_neg_reg[31:0];
      rdata_reg[1] <= pins.dq[31:0];
    end
    if (!wr_op_reg && st_reg == SSB_ST_DRAIN) begin
      rdata_reg[2] <= cap_neg_reg[31:0];
      rdata_reg[3] <= pins.dq[31:0];
    end
  end

  // write words: even words launched at falling edges, odd at rising edges,
  // so each is stable at the edge that captures it
  always_ff @(posedge clock) begin
    if (srst) begin
      dq_pos_reg <= '0;
      dq_on_reg  <= 1'b0;
    end else begin
      dq_on_reg <= wr_op_reg && (st_next == SSB_ST_CONT || st_next == SSB_ST_TAIL ||
                                 st_next == SSB_ST_DRAIN);
      if (st_reg == SSB_ST_CONT) dq_pos_reg <= DATA_W'(wdata_reg[1]) ^ dq_neg_reg;
      if (st_reg == SSB_ST_TAIL) dq_pos_reg <= DATA_W'(wdata_reg[3]) ^ dq_neg_reg;
    end
  end

  always_ff @(negedge clock) begin
    if (srst) dq_neg_reg <= '0;
    else if (st_reg == SSB_ST_CONT) dq_neg_reg <= DATA_W'(wdata_reg[0]) ^ dq_pos_reg;
    else if (st_reg == SSB_ST_TAIL) dq_neg_reg <= DATA_W'(wdata_reg[2]) ^ dq_pos_reg;
  end

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  assign pins.addr             = addr_reg[ADDR_W-1:0];
  assign pins.advance_load     = (st_reg == SSB_ST_CONT);
  assign pins.primary_select_n = ~(st_reg == SSB_ST_CMD || st_reg == SSB_ST_CONT);
  assign pins.write_n          = ~wr_op_reg;
  assign pins.prog_select_a    = bank_reg[0];
  assign pins.prog_select_b    = bank_reg[1];
  assign pins.dq_ctl_out       = dq_pos_reg ^ dq_neg_reg;
  assign pins.dq_ctl_oe_n      = ~dq_on_reg;

endmodule

/* testbench/ssb_link_asserts.sv */
// pin-level checks on the link between burst memory controller and device
`timescale 1ns/10ps

module ssb_link_asserts (
  input wire logic clock,
  input wire logic srst,
  input wire logic polarity_strap_a,
  input wire logic polarity_strap_b,
  input wire logic advance_load,
  input wire logic write_n,
  input wire logic primary_select_n,
  input wire logic prog_select_a,
  input wire logic prog_select_b,
  input wire logic dq_ctl_oe_n,
  input wire logic dq_dev_oe_n,
  input wire logic echo_clock_one,
  input wire logic echo_clock_one_n,
  input wire logic echo_clock_two,
  input wire logic echo_clock_two_n,
  input wire logic echo_oe_n
);
  // ----------------------------------------
  // command decode as the device sees it
  // ----------------------------------------
  // straps pass a sync stage, so decoding waits a few cycles after reset
  logic [2:0] age_reg;
  wire        settled  = age_reg == 3'h7;
  wire        hit_a    = prog_select_a == polarity_strap_a;
  wire        hit_b    = prog_select_b == polarity_strap_b;
  wire        load_cmd = settled && !advance_load;
  wire        rd_cmd   = load_cmd && hit_a && hit_b && !primary_select_n && write_n;
  wire        wr_cmd   = load_cmd && hit_a && hit_b && !primary_select_n && !write_n;
  wire        bank_off = load_cmd && !(hit_a && hit_b);
  wire        prim_off = load_cmd && hit_a && hit_b && primary_select_n;

  always_ff @(posedge clock) begin
    if (srst) begin
      age_reg <= 3'h0;
    end else if (!settled) begin
      age_reg <= age_reg + 3'h1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_read_drives_bus: assert property (rd_cmd |-> ##2 !dq_dev_oe_n ##1 !dq_dev_oe_n)
    else $error("read burst not driven");
  a_drive_has_read: assert property (!dq_dev_oe_n |-> $past(rd_cmd, 2) || $past(rd_cmd, 3))
    else $error("device drives without read");
  a_desel_data_off: assert property ((bank_off || prim_off || wr_cmd) |-> ##2 dq_dev_oe_n)
    else $error("data not released");
  a_bank_echo_off: assert property (bank_off |-> ##2 echo_oe_n)
    else $error("echo not released");
  a_prim_echo_on: assert property ((prim_off || rd_cmd || wr_cmd) |-> ##2 !echo_oe_n)
    else $error("echo stopped without bank deselect");
  a_echo_pair_phase: assert property (!echo_oe_n |->
      echo_clock_one_n != echo_clock_one && echo_clock_two == echo_clock_one &&
      echo_clock_two_n == echo_clock_one_n)
    else $error("echo outputs out of phase");
  a_write_bus_turn: assert property (wr_cmd |-> ##1 !dq_ctl_oe_n [*3] ##1 dq_ctl_oe_n)
    else $error("write data window wrong");
  a_burst_sequence: assert property ((rd_cmd || wr_cmd) |=>
      advance_load ##1 (!advance_load && primary_select_n))
    else $error("burst sequence wrong");
  a_continue_origin: assert property (settled && advance_load |->
      !$past(advance_load) && !$past(primary_select_n))
    else $error("continue without command");
  a_one_bus_driver: assert property (!(!dq_dev_oe_n && !dq_ctl_oe_n))
    else $error("data bus driven twice");
endmodule

/* testbench/test_ddr_sync_sram_burst_enable_logic.sv */
// self-checking bench: controller and device joined over the burst memory pins
`timescale 1ns/10ps
`include "ssb_params.svh"

module test_ddr_sync_sram_burst_enable_logic import ssb_pkg::*;;
  localparam int         AW        = 6;
  localparam logic [1:0] HOME_BANK = 2'h1;

  logic        clock;
  logic        srst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        strong_drive;
  logic        strap_a;
  logic        strap_b;
  logic        drive_strap;
  logic [31:0] rq;
  logic        re;
  logic [31:0] mem [int];
  int          error_cnt;
  int          checks_done;

  // ----------------------------------------
  // both ends and the checker
  // ----------------------------------------
  // device strapped as bank 1: select a active high, select b active low
  ssb_if #(.ADDR_W(AW), .DATA_W(36)) ssb_if_inst ();
  ssb_ctrl #(.ADDR_W(AW), .DATA_W(36)) ssb_ctrl_inst (.clock(clock), .srst(srst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(ssb_if_inst.ctrl));
  ssb_device #(.ADDR_W(AW), .DATA_W(36)) ssb_device_inst (.clock(clock), .srst(srst),
    .polarity_strap_a(strap_a), .polarity_strap_b(strap_b), .drive_strength_strap(drive_strap),
    .strong_drive(strong_drive), .pins(ssb_if_inst.device));
  ssb_link_asserts ssb_link_asserts_inst (.clock(clock), .srst(srst),
    .polarity_strap_a(strap_a), .polarity_strap_b(strap_b),
    .advance_load(ssb_if_inst.advance_load), .write_n(ssb_if_inst.write_n),
    .primary_select_n(ssb_if_inst.primary_select_n),
    .prog_select_a(ssb_if_inst.prog_select_a), .prog_select_b(ssb_if_inst.prog_select_b),
    .dq_ctl_oe_n(ssb_if_inst.dq_ctl_oe_n), .dq_dev_oe_n(ssb_if_inst.dq_dev_oe_n),
    .echo_clock_one(ssb_if_inst.echo_clock_one),
    .echo_clock_one_n(ssb_if_inst.echo_clock_one_n),
    .echo_clock_two(ssb_if_inst.echo_clock_two),
    .echo_clock_two_n(ssb_if_inst.echo_clock_two_n), .echo_oe_n(ssb_if_inst.echo_oe_n));

  always #5 clock = ~clock;

  // ----------------------------------------
  // bench tasks
  // ----------------------------------------
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp, input string what);
    cmp_word({31'h0000_0000, got}, {31'h0000_0000, exp}, what);
  endtask

  // memory word for pin address p and burst step k: base pair first, then the other
  function automatic int idx(input logic [AW-1:0] p, input int k);
    return int'({p[AW-1:1], p[0] ^ k[1], k[0]});
  endfunction

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    @(posedge clock);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic burst(input logic wr, input logic [1:0] bank, input logic [AW-1:0] p);
    logic [31:0] w;
    int          n;
    apb(1'b1, `SSB_OFF_ADDR, 32'(p), rq, re);
    for (int k = 0; k < 4 && wr; k++) begin
      w = $urandom;
      apb(1'b1, `SSB_OFF_WDATA0 + 12'(4 * k), w, rq, re);
      if (bank == HOME_BANK) begin
        mem[idx(p, k)] = w;
      end
    end
    apb(1'b1, `SSB_OFF_CMD, {28'h000_0000, bank, wr, 1'b1}, rq, re);
    n = 0;
    do begin
      apb(1'b0, `SSB_OFF_STATUS, 32'h0000_0000, rq, re);
      n++;
    end while (rq[`SSB_STAT_DONE] !== 1'b1 && n < 20);
    cmp_word(rq, 32'h0000_0002, "status after burst");
    cmp_bit(ssb_if_inst.echo_oe_n, bank != HOME_BANK, "echo enable at idle");
    cmp_bit(ssb_if_inst.dq_dev_oe_n, 1'b1, "data released at idle");
    for (int k = 0; k < 4 && !wr; k++) begin
      apb(1'b0, `SSB_OFF_RDATA0 + 12'(4 * k), 32'h0000_0000, rq, re);
      cmp_word(rq, (bank == HOME_BANK) ? mem[idx(p, k)] : 32'h0000_0000, "word");
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [AW-1:0] a;
    clock = 1'b0;
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    strap_a = 1'b1;
    strap_b = 1'b0;
    drive_strap = 1'b1;
    error_cnt = 0;
    checks_done = 0;
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    void'($urandom(16860));
    apb(1'b0, `SSB_OFF_STATUS, 32'h0000_0000, rq, re);
    cmp_word(rq, 32'h0000_0000, "status after reset");
    cmp_bit(strong_drive, 1'b0, "drive strength");
    // the strap is static in use; a change only has to settle through the sync stages
    drive_strap <= 1'b0;
    repeat (6) @(posedge clock);
    cmp_bit(strong_drive, 1'b1, "drive strength low strap");
    apb(1'b1, 12'h0F0, 32'hFFFF_FFFF, rq, re);
    cmp_bit(re, 1'b1, "unmapped write");
    apb(1'b0, 12'h0F0, 32'h0000_0000, rq, re);
    cmp_word(rq, 32'h0000_0000, "unmapped read");
    // corners at both ends of the address space, odd steps read from the other pair
    for (int i = 0; i < 10; i++) begin
      a = (i == 0) ? '0 : (i == 1) ? '1 : AW'($urandom);
      burst(1'b1, HOME_BANK, a);
      burst(1'b0, HOME_BANK, a ^ AW'(i % 2));
    end
    // every bank code: only the strapped one may store or drive
    for (int b = 0; b < 4; b++) begin
      a = AW'($urandom);
      burst(1'b1, HOME_BANK, a);
      burst(1'b1, 2'(b), a);
      burst(1'b0, 2'(b), a);
      burst(1'b0, HOME_BANK, a);
    end
    print_verdict();
  end

  initial begin
    #200_000;
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule
